// *** inc/ebaw_cfg.svh ***
// Constants of the expansion bus arbitration and wait-state block
`ifndef EBAW_CFG_SVH
`define EBAW_CFG_SVH
// Register word indexes on the Avalon-MM slave
`define EBAW_IDX_BUS_CTRL 2'h0
`define EBAW_IDX_OP_MODE 2'h1
`define EBAW_IDX_COMMAND 2'h2
`define EBAW_IDX_STATUS 2'h3
// bus_control_reg fields
`define EBAW_BUSCTL_WS_LSB 0
`define EBAW_BUSCTL_WS_MSB 3
`define EBAW_BUSCTL_REQUEST_HOLD 4
`define EBAW_BUSCTL_RESET 32'h0000_0001
// operating_mode_reg fields
`define EBAW_OPMODE_ACK_SYNC_SELECT 0
`define EBAW_OPMODE_DRAM_ENABLE 1
`define EBAW_OPMODE_ASYNC_ARB 13
`define EBAW_OPMODE_RESET 32'h0000_2001
// Command register fields
`define EBAW_CMD_WRITE 0
`define EBAW_CMD_DRAM 1
// Far end: idle cycles between withdrawing grant and granting again
`define EBAW_GRANT_GAP 4'h4
`endif

// *** inc/ebaw_pkg.sv ***
// Types shared by both ends of the expansion bus
package ebaw_pkg;
  // Arbitration and cycle states, one-hot
  typedef enum logic [5:0] {
    ST_SLAVE = 6'h01,
    ST_PEND = 6'h02,
    ST_OWN = 6'h04,
    ST_CYC = 6'h08,
    ST_DONE = 6'h10,
    ST_REL = 6'h20
  } ebaw_state_type;

  // Whole state of the device end
  typedef struct packed {
    ebaw_state_type st;
    logic [3:0] ws_cnt;
    logic [7:0] ws_taken;
    logic pending;
    logic dir_wr;
    logic use_cas;
    logic [3:0] wait_states;
    logic request_hold;
    logic ack_sync_select;
    logic mastership_enable_dram;
    logic async_arbitration_enable;
    logic [2:0] grant_s;
    logic [2:0] busy_s;
    logic [2:0] ack_s;
    logic grant_f;
    logic busy_f;
    logic ack_f;
    logic waitreq;
    logic [31:0] rdata;
    logic wr_n;
    logic rd_n;
    logic strobe_oe;
    logic cas_n;
    logic cas_oe;
    logic req_n;
    logic busy_o;
    logic busy_oe;
  } ebaw_dev_type;

  // Whole state of the far end
  typedef struct packed {
    logic gnt_n;
    logic [3:0] gap_cnt;
    logic other_busy;
    logic ack_n;
    logic [3:0] ack_cnt;
    logic strobe_q;
    logic [7:0] accesses;
  } ebaw_far_type;
endpackage

// *** inc/ebaw_if.sv ***
// Pin-level carrier joining the device end and the far end
`timescale 1ns/1ps
interface ebaw_if;
  logic wr_n_o, wr_n_oe;
  logic rd_n_o, rd_n_oe;
  logic cas_n_o, cas_n_oe;
  logic bus_request_n;
  logic bus_grant_n;
  logic transfer_ack_n;
  logic busy_dev_o, busy_dev_oe;
  logic busy_far_o, busy_far_oe;
  // Resolved levels; undriven lines float high on pull-ups
  logic wr_n, rd_n, cas_n, bus_busy_n;
  assign wr_n = wr_n_oe ? wr_n_o : 1'b1;
  assign rd_n = rd_n_oe ? rd_n_o : 1'b1;
  assign cas_n = cas_n_oe ? cas_n_o : 1'b1;
  assign bus_busy_n = (busy_dev_oe & ~busy_dev_o) | (busy_far_oe & ~busy_far_o) ? 1'b0 : 1'b1;
  modport dev (output wr_n_o, wr_n_oe, rd_n_o, rd_n_oe, cas_n_o, cas_n_oe,
               bus_request_n, busy_dev_o, busy_dev_oe,
               input bus_grant_n, transfer_ack_n, bus_busy_n);
  modport far (output bus_grant_n, transfer_ack_n, busy_far_o, busy_far_oe,
               input wr_n, rd_n, cas_n, bus_request_n, bus_busy_n);
endinterface

// *** logic/ebaw_far.sv ***
// Far end: external memory responder and bus arbitration circuit
`timescale 1ns/1ps
`include "ebaw_cfg.svh"
module ebaw_far
  import ebaw_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic grant_enable_in,
  input wire logic other_master_in,
  input wire logic [3:0] ack_delay_in,
  output logic [7:0] accesses_out,
  ebaw_if.far bus
);
  // Shares mclk with the device, so pins are taken without synchronisers
  ebaw_far_type s_r, s_nxt;
  logic strobe;

  assign strobe = ~bus.wr_n | ~bus.rd_n;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.strobe_q = strobe;
    // Grant with a gap after each withdrawal
    if (s_r.gap_cnt != 4'h0) begin
      s_nxt.gap_cnt = s_r.gap_cnt - 4'h1;
    end
    if (grant_enable_in && s_r.gap_cnt == 4'h0) begin
      s_nxt.gnt_n = 1'b0;
    end else begin
      s_nxt.gnt_n = 1'b1;
      if (!s_r.gnt_n) begin
        s_nxt.gap_cnt = `EBAW_GRANT_GAP;
      end
    end
    // Another master pulls busy low when asked
    s_nxt.other_busy = other_master_in;
    // Acknowledge inactive at cycle start, active after the delay
    if (strobe && !s_r.strobe_q) begin
      s_nxt.ack_n = 1'b1;
      s_nxt.ack_cnt = ack_delay_in;
    end else if (strobe) begin
      if (s_r.ack_cnt != 4'h0) begin
        s_nxt.ack_cnt = s_r.ack_cnt - 4'h1;
      end else begin
        s_nxt.ack_n = 1'b0;
      end
    end else begin
      // Back to inactive before the next cycle
      s_nxt.ack_n = 1'b1;
    end
    if (!strobe && s_r.strobe_q) begin
      s_nxt.accesses = s_r.accesses + 8'h01;
    end
  end

  // ----------------------------------------
  // State register; changes only on mclk, as synchronous mode needs
  // ----------------------------------------
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{gnt_n: 1'b1, gap_cnt: 4'h0, other_busy: 1'b0, ack_n: 1'b1,
               ack_cnt: 4'h0, strobe_q: 1'b0, accesses: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.bus_grant_n = s_r.gnt_n;
  assign bus.transfer_ack_n = s_r.ack_n;
  assign bus.busy_far_o = 1'b0;
  assign bus.busy_far_oe = s_r.other_busy;
  assign accesses_out = s_r.accesses;
endmodule

// *** logic/ebaw_dev.sv ***
// Device end: strobes, acknowledge wait states and bus arbitration
//
// Added by the designer: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "ebaw_cfg.svh"
module ebaw_dev
  import ebaw_pkg::*;
(
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  ebaw_if.dev bus
);
  ebaw_dev_type s_r, s_nxt;
  logic grant; // Effective grant, active high
  logic busy; // Effective bus busy, active high
  logic ack; // Effective acknowledge, active high
  logic take; // Avalon register write accepted this cycle
  logic master; // State owns the bus

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Three-stage filter: value moves only when stages two and three agree
  function automatic logic filt(input logic [2:0] sh, input logic cur);
    filt = (sh[1] == sh[2]) ? sh[2] : cur;
  endfunction

  // Master states: bus owned, strobes and busy driven
  function automatic logic is_master(input ebaw_state_type st);
    is_master = (st == ST_OWN) || (st == ST_CYC) || (st == ST_DONE) || (st == ST_REL);
  endfunction

  // ----------------------------------------
  // Input selection
  // ----------------------------------------
  // Raw pins need set-up and hold to mclk; filtered ones cost latency
  always_comb begin
    grant = s_r.async_arbitration_enable ? s_r.grant_f : ~bus.bus_grant_n;
    busy = s_r.async_arbitration_enable ? s_r.busy_f : ~bus.bus_busy_n;
    // Must be synchronised when running fast
    ack = s_r.ack_sync_select ? s_r.ack_f : ~bus.transfer_ack_n;
    master = is_master(s_r.st);
    take = avs_write_in && !s_r.waitreq;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Synchroniser stages, stored active high
    s_nxt.grant_s = {s_r.grant_s[1:0], ~bus.bus_grant_n};
    s_nxt.busy_s = {s_r.busy_s[1:0], ~bus.bus_busy_n};
    s_nxt.ack_s = {s_r.ack_s[1:0], ~bus.transfer_ack_n};
    s_nxt.grant_f = filt(s_r.grant_s, s_r.grant_f);
    s_nxt.busy_f = filt(s_r.busy_s, s_r.busy_f);
    s_nxt.ack_f = filt(s_r.ack_s, s_r.ack_f);

    // Avalon slave: waitrequest drops for one cycle per request
    if ((avs_read_in || avs_write_in) && s_r.waitreq) begin
      s_nxt.waitreq = 1'b0;
      case (avs_address_in)
        `EBAW_IDX_BUS_CTRL: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rdata[`EBAW_BUSCTL_WS_MSB:`EBAW_BUSCTL_WS_LSB] = s_r.wait_states;
          s_nxt.rdata[`EBAW_BUSCTL_REQUEST_HOLD] = s_r.request_hold;
        end
        `EBAW_IDX_OP_MODE: begin
          s_nxt.rdata = 32'h0;
          s_nxt.rdata[`EBAW_OPMODE_ACK_SYNC_SELECT] = s_r.ack_sync_select;
          s_nxt.rdata[`EBAW_OPMODE_DRAM_ENABLE] = s_r.mastership_enable_dram;
          s_nxt.rdata[`EBAW_OPMODE_ASYNC_ARB] = s_r.async_arbitration_enable;
        end
        `EBAW_IDX_STATUS: begin
          s_nxt.rdata = {16'h0, s_r.ws_taken, 1'b0, s_r.st == ST_CYC, ~s_r.busy_oe,
                         ~s_r.req_n, master, s_r.st == ST_PEND, 1'b0, s_r.pending};
        end
        default: begin
          // Command register reads as zero
          s_nxt.rdata = 32'h0;
        end
      endcase
    end else begin
      s_nxt.waitreq = 1'b1;
    end

    // Register writes take effect at the edge that ends the wait
    if (take) begin
      case (avs_address_in)
        `EBAW_IDX_BUS_CTRL: begin
          s_nxt.wait_states = avs_writedata_in[`EBAW_BUSCTL_WS_MSB:`EBAW_BUSCTL_WS_LSB];
          s_nxt.request_hold = avs_writedata_in[`EBAW_BUSCTL_REQUEST_HOLD];
        end
        `EBAW_IDX_OP_MODE: begin
          s_nxt.ack_sync_select = avs_writedata_in[`EBAW_OPMODE_ACK_SYNC_SELECT];
          s_nxt.mastership_enable_dram = avs_writedata_in[`EBAW_OPMODE_DRAM_ENABLE];
          s_nxt.async_arbitration_enable = avs_writedata_in[`EBAW_OPMODE_ASYNC_ARB];
        end
        `EBAW_IDX_COMMAND: begin
          // A new command while one is pending is dropped
          if (!s_r.pending) begin
            s_nxt.pending = 1'b1;
            s_nxt.dir_wr = avs_writedata_in[`EBAW_CMD_WRITE];
            s_nxt.use_cas = avs_writedata_in[`EBAW_CMD_DRAM];
          end
        end
        default: begin
          // Status is read-only
          s_nxt.pending = s_r.pending;
        end
      endcase
    end

    // Arbitration and cycle sequencing
    case (s_r.st)
      ST_SLAVE: begin
        // Only an external access, or the hold bit, leads to mastership
        if ((s_r.pending || s_r.request_hold) && grant) begin
          s_nxt.st = ST_PEND;
        end
      end
      ST_PEND: begin
        if (!grant) begin
          s_nxt.st = ST_SLAVE;
        end else if (!busy) begin
          s_nxt.st = ST_OWN;
        end
      end
      ST_OWN: begin
        // Parked here while granted, busy held low
        if (!grant) begin
          s_nxt.st = ST_REL;
        end else if (s_r.pending) begin
          s_nxt.st = ST_CYC;
          s_nxt.ws_cnt = s_r.wait_states;
          s_nxt.ws_taken = 8'h00;
        end
      end
      ST_CYC: begin
        // Programmed minimum first, then acknowledge decides unless wait states are zero
        if (s_r.ws_cnt != 4'h0) begin
          s_nxt.ws_cnt = s_r.ws_cnt - 4'h1;
          s_nxt.ws_taken = s_r.ws_taken + 8'h01;
        end else if (s_r.wait_states == 4'h0 || ack) begin
          // Acknowledge is looked at only here, in an own cycle after the count
          // Zero wait states ignore acknowledge else ends next clock
          s_nxt.st = ST_DONE;
        end else begin
          // Stretch; saturating counter only limits the report
          if (s_r.ws_taken != 8'hFF) begin
            s_nxt.ws_taken = s_r.ws_taken + 8'h01;
          end
        end
      end
      ST_DONE: begin
        s_nxt.pending = 1'b0;
        // Grant withdrawal is honoured next, in ST_OWN, between cycles
        s_nxt.st = ST_OWN;
      end
      ST_REL: begin
        s_nxt.st = ST_SLAVE;
      end
      default: begin
        s_nxt.st = ST_SLAVE;
      end
    endcase

    // Pin drivers follow the next state so every pin is a flop
    s_nxt.strobe_oe = is_master(s_nxt.st);
    s_nxt.wr_n = !(s_nxt.st == ST_CYC && s_nxt.dir_wr);
    s_nxt.rd_n = !(s_nxt.st == ST_CYC && !s_nxt.dir_wr);
    s_nxt.cas_n = !(s_nxt.st == ST_CYC && s_nxt.use_cas);
    s_nxt.cas_oe = is_master(s_nxt.st) || s_nxt.mastership_enable_dram;
    // Busy low while master, one high pulse on release, then float
    s_nxt.busy_oe = is_master(s_nxt.st);
    s_nxt.busy_o = (s_nxt.st == ST_REL);
    // Request from external need or hold bit only
    s_nxt.req_n = !((s_nxt.pending && s_nxt.st != ST_DONE) || s_nxt.request_hold);
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Reset parks arbitration in slave with request inactive
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_r <= '{st: ST_SLAVE, ws_cnt: 4'h0, ws_taken: 8'h00, pending: 1'b0,
               dir_wr: 1'b0, use_cas: 1'b0,
               wait_states: 4'h1, request_hold: 1'b0,
               ack_sync_select: 1'b1, mastership_enable_dram: 1'b0,
               async_arbitration_enable: 1'b1,
               grant_s: 3'h0, busy_s: 3'h0, ack_s: 3'h0,
               grant_f: 1'b0, busy_f: 1'b0, ack_f: 1'b0,
               waitreq: 1'b1, rdata: 32'h0,
               wr_n: 1'b1, rd_n: 1'b1, strobe_oe: 1'b0,
               cas_n: 1'b1, cas_oe: 1'b0,
               req_n: 1'b1, busy_o: 1'b1, busy_oe: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs, straight from the state register
  // ----------------------------------------
  assign avs_readdata_out = s_r.rdata;
  assign avs_waitrequest_out = s_r.waitreq;
  assign bus.wr_n_o = s_r.wr_n;
  assign bus.wr_n_oe = s_r.strobe_oe;
  assign bus.rd_n_o = s_r.rd_n;
  assign bus.rd_n_oe = s_r.strobe_oe;
  assign bus.cas_n_o = s_r.cas_n;
  assign bus.cas_n_oe = s_r.cas_oe;
  assign bus.bus_request_n = s_r.req_n;
  assign bus.busy_dev_o = s_r.busy_o;
  assign bus.busy_dev_oe = s_r.busy_oe;
endmodule

// *** test/ebaw_asserts.sv ***
// Concurrent checks on the expansion bus pins between the two ends
`timescale 1ns/1ps
module ebaw_asserts (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic wr_n_o,
  input wire logic wr_n_oe,
  input wire logic rd_n_o,
  input wire logic rd_n_oe,
  input wire logic cas_n_o,
  input wire logic cas_n_oe,
  input wire logic bus_grant_n,
  input wire logic transfer_ack_n,
  input wire logic busy_dev_o,
  input wire logic busy_dev_oe,
  input wire logic bus_busy_n,
  input wire logic wr_n,
  input wire logic rd_n
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  logic own; // Device drives busy low, so it holds the bus
  logic stb_n; // Low while either data strobe is low
  assign own = busy_dev_oe & ~busy_dev_o;
  assign stb_n = wr_n & rd_n;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_wr_own; (wr_n_oe && !wr_n_o) |-> own; endproperty
  property p_rd_own; (rd_n_oe && !rd_n_o) |-> own; endproperty
  property p_cas_own; (cas_n_oe && !cas_n_o) |-> own; endproperty
  property p_float; !busy_dev_oe |-> !wr_n_oe && !rd_n_oe; endproperty
  property p_take_free; $rose(own) |-> $past(bus_busy_n); endproperty
  property p_take_grant; $rose(own) |-> !$past(bus_grant_n); endproperty
  property p_release; $fell(busy_dev_oe) |-> $past(busy_dev_o); endproperty
  // Bound covers the longest stretched cycle the bench makes
  property p_grant_drop; ($rose(bus_grant_n) && own) |-> ##[1:60] !busy_dev_oe; endproperty
  property p_ack_end; (!stb_n && !transfer_ack_n) |-> ##[1:20] stb_n; endproperty
  a_wr_own: assert property (p_wr_own)
    else $error("write strobe low without bus ownership");
  a_rd_own: assert property (p_rd_own)
    else $error("read strobe low without bus ownership");
  a_cas_own: assert property (p_cas_own)
    else $error("column strobe low without bus ownership");
  a_float: assert property (p_float)
    else $error("strobes driven while busy not driven");
  a_take_free: assert property (p_take_free)
    else $error("busy taken while bus was busy");
  a_take_grant: assert property (p_take_grant)
    else $error("busy taken without grant");
  a_release: assert property (p_release)
    else $error("busy floated without driving it high");
  a_grant_drop: assert property (p_grant_drop)
    else $error("bus kept after grant withdrawn");
  a_ack_end: assert property (p_ack_end)
    else $error("cycle not ended after acknowledge");
  c_long: cover property (!stb_n [*4]);
  c_release: cover property ($fell(busy_dev_oe));
  c_park: cover property (own && !bus_grant_n && stb_n);
endmodule

// *** test/testbench.sv ***
// Self-checking bench joining the device end and the far end
`timescale 1ns/1ps
`include "ebaw_cfg.svh"
module testbench;
  // ----------------------------------------
  // Stimulus, results and bookkeeping
  // ----------------------------------------
  logic mclk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [1:0] avs_address_in = 2'h0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = 32'h0;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic grant_enable_in = 1'b0;
  logic other_master_in = 1'b0;
  logic [3:0] ack_delay_in = 4'h0;
  logic [7:0] accesses_out;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0; // Cycles since start, for the hang limit
  logic [31:0] len = 32'h0; // Length of the strobe cycle in flight
  logic [31:0] last_len = 32'h0; // Length of the last finished one
  logic saw_wr = 1'b0;
  logic saw_rd = 1'b0;
  logic saw_cas = 1'b0;
  logic [31:0] rd; // Data of the last register read
  ebaw_if bus_if ();
  ebaw_dev ebaw_dev_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .bus(bus_if.dev));
  ebaw_far ebaw_far_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .grant_enable_in(grant_enable_in), .other_master_in(other_master_in),
    .ack_delay_in(ack_delay_in), .accesses_out(accesses_out), .bus(bus_if.far));
  ebaw_asserts ebaw_asserts_i (.mclk_in(mclk_in), .resetn_in(resetn_in),
    .wr_n_o(bus_if.wr_n_o), .wr_n_oe(bus_if.wr_n_oe), .rd_n_o(bus_if.rd_n_o),
    .rd_n_oe(bus_if.rd_n_oe), .cas_n_o(bus_if.cas_n_o), .cas_n_oe(bus_if.cas_n_oe),
    .bus_grant_n(bus_if.bus_grant_n), .transfer_ack_n(bus_if.transfer_ack_n),
    .busy_dev_o(bus_if.busy_dev_o), .busy_dev_oe(bus_if.busy_dev_oe),
    .bus_busy_n(bus_if.bus_busy_n), .wr_n(bus_if.wr_n), .rd_n(bus_if.rd_n));
  initial begin
    forever #25 mclk_in = ~mclk_in;
  end
  // Strobe width monitor and hang limit; the limit is far above the run
  always @(posedge mclk_in) begin
    cyc++;
    if ((bus_if.wr_n & bus_if.rd_n) === 1'b0) begin
      len <= len + 32'h1;
    end else if (len != 32'h0) begin
      last_len <= len;
      len <= 32'h0;
    end
    if (bus_if.wr_n === 1'b0) saw_wr <= 1'b1;
    if (bus_if.rd_n === 1'b0) saw_rd <= 1'b1;
    if (bus_if.cas_n === 1'b0) saw_cas <= 1'b1;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chkw(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // One Avalon access; held until waitrequest is sampled low
  task automatic av(input logic [1:0] a, input logic w, input logic [31:0] d);
    @(posedge mclk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= w;
    avs_read_in <= ~w;
    @(posedge mclk_in);
    while (avs_waitrequest_out !== 1'b0) begin
      @(posedge mclk_in);
    end
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask
  // Polls until the queued external cycle has finished
  task automatic wait_idle();
    av(`EBAW_IDX_STATUS, 1'b0, 32'h0);
    while (rd[0] !== 1'b0) begin
      av(`EBAW_IDX_STATUS, 1'b0, 32'h0);
    end
    repeat (3) @(posedge mclk_in);
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chkb(bus_if.bus_request_n, 1'b1);
    chkb(bus_if.wr_n_oe | bus_if.rd_n_oe | bus_if.busy_dev_oe, 1'b0);
    av(`EBAW_IDX_BUS_CTRL, 1'b0, 32'h0);
    chkw(rd, `EBAW_BUSCTL_RESET);
    av(`EBAW_IDX_OP_MODE, 1'b0, 32'h0);
    chkw(rd, `EBAW_OPMODE_RESET);
  endtask
  // Request held by software alone, grant still off
  task automatic t_hold();
    av(`EBAW_IDX_BUS_CTRL, 1'b1, 32'h11);
    repeat (3) @(posedge mclk_in);
    chkb(bus_if.bus_request_n, 1'b0);
    av(`EBAW_IDX_BUS_CTRL, 1'b1, 32'h0);
    repeat (3) @(posedge mclk_in);
    chkb(bus_if.bus_request_n, 1'b1);
    chkb(bus_if.busy_dev_oe, 1'b0);
  endtask
  // Another master holds busy; zero wait states with a late acknowledge
  task automatic t_busy();
    other_master_in <= 1'b1;
    ack_delay_in <= 4'h5;
    grant_enable_in <= 1'b1;
    av(`EBAW_IDX_COMMAND, 1'b1, 32'h1);
    repeat (20) @(posedge mclk_in);
    chkb(bus_if.busy_dev_oe, 1'b0);
    chkb(saw_wr, 1'b0);
    // Status: pending, waiting on busy, request active, busy not driven
    av(`EBAW_IDX_STATUS, 1'b0, 32'h0);
    chkw(rd, 32'h0000_0035);
    other_master_in <= 1'b0;
    wait_idle();
    chkb(saw_wr, 1'b1);
    chkw(last_len, 32'h1);
    chkb(bus_if.bus_request_n, 1'b1);
    chkb(bus_if.bus_busy_n, 1'b0);
  endtask
  // Programmed wait states win, then a late acknowledge stretches
  task automatic t_wait();
    av(`EBAW_IDX_OP_MODE, 1'b1, 32'h2);
    av(`EBAW_IDX_BUS_CTRL, 1'b1, 32'h3);
    ack_delay_in <= 4'h0;
    av(`EBAW_IDX_COMMAND, 1'b1, 32'h2);
    wait_idle();
    chkw(last_len, 32'h4);
    chkb(saw_rd, 1'b1);
    chkb(saw_cas, 1'b1);
    // Status: parked master, three programmed wait states taken
    av(`EBAW_IDX_STATUS, 1'b0, 32'h0);
    chkw(rd, 32'h0000_0308);
    av(`EBAW_IDX_BUS_CTRL, 1'b1, 32'h1);
    ack_delay_in <= 4'hA;
    av(`EBAW_IDX_COMMAND, 1'b1, 32'h1);
    wait_idle();
    chkb(last_len >= 32'hA, 1'b1);
  endtask
  // Grant withdrawn in mid-cycle: cycle completes, then the bus is let go
  task automatic t_drop();
    av(`EBAW_IDX_COMMAND, 1'b1, 32'h1);
    while (bus_if.wr_n !== 1'b0) begin
      @(posedge mclk_in);
    end
    grant_enable_in <= 1'b0;
    wait_idle();
    chkw({24'h0, accesses_out}, 32'h4);
    repeat (10) @(posedge mclk_in);
    chkb(bus_if.busy_dev_oe, 1'b0);
    chkb(bus_if.bus_busy_n, 1'b1);
    chkb(bus_if.wr_n_oe | bus_if.rd_n_oe, 1'b0);
    av(`EBAW_IDX_OP_MODE, 1'b1, 32'h0);
    repeat (3) @(posedge mclk_in);
    chkb(bus_if.cas_n_oe, 1'b0);
  endtask
  initial begin
    repeat (3) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_hold();
    t_busy();
    t_wait();
    t_drop();
    stop_test();
  end
endmodule
